// *** logic/sdc_pkg.sv ***
// Constants, command codes and carrier types for the SDRAM command/burst core.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
`default_nettype none
package sdc_pkg;
  // ==================================================================
  // Geometry
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int BA_W = 2;
  localparam int DQ_W = 16;
  localparam int NBANK = 4;
  // ==================================================================
  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  // ==================================================================
  // Mode register layout
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int WB_BIT = 9;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] BL_MAXC = 3'h3;
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h2;
  localparam logic [ROW_W-1:0] MODE_RST = 12'h020;
  localparam logic [ROW_W-1:0] EXT_RST = 12'h000;
  // ==================================================================
  // Wishbone map
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_MODE = 2'h1;
  localparam logic [1:0] REG_EXT = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  localparam int WB_AW = 4;
  // ==================================================================
  // Types
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdc_cmd_s;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} sdc_state_e;
endpackage : sdc_pkg
`default_nettype wire

// *** logic/sdc_core.sv ***
// Command decode, mode registers, bank state and burst sequencing of the memory.
// Assumes the controller keeps power-up ordering; status and a command block bit via Wishbone.
//
// Our own choices: register access over Wishbone and the placing of the registers.
`default_nettype none
// Summary of operation
// - All inputs sampled on rising clock only
// - Low clock gate freezes bursts and commands
// - While powered down, inputs ignored until exit
// - Select high masks every command
// - Four strobes together form the command
// - Masks block write bytes, float reads later
// - Bank select picks bank or mode register
// - Row, column and op-code latched from address
// - Bit 10: auto precharge, or all-bank precharge
// - Mode register held until reloaded
// - Mode fields: length, type, latency, mode, write
// - Lengths 1,2,4,8; full page sequential only
// - Full page wraps in row, terminate ends
// - Burst wraps within aligned block
// - Sequential increments, interleaved XORs counter
// - Length one ignores burst type
// - Read data driven after edge n+m-1
// - Select 10 on load writes extended register
// - Operating mode bits zero for normal use
// - Single-write bit makes writes one location
module sdc_core
  import sdc_pkg::*;
#(
  parameter int MEM_AW = 23
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clock_gate_input,
  input wire sdc_pkg::sdc_cmd_s cmd,
  input wire logic bank_sel_lo,
  input wire logic bank_sel_hi,
  input wire logic [sdc_pkg::ROW_W-1:0] addr_bus,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [sdc_pkg::DQ_W-1:0] data_io_bus_in,
  output logic [sdc_pkg::DQ_W-1:0] data_io_bus_out,
  output logic [sdc_pkg::DQ_W-1:0] data_io_bus_oe,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sdc_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import sdc_pkg::*;
  // ==================================================================
  // Command decode
  logic cke;
  logic [3:0] code;
  logic [1:0] ba;
  logic cmd_ok;
  logic blk_q, blk_d;
  assign cke = clock_gate_input;
  assign code = cmd;
  assign ba = {bank_sel_hi, bank_sel_lo};
  // Gated clock also covers power-down: nothing is decoded while low
  assign cmd_ok = cke && !cmd.cs_n && !blk_q;
  // ==================================================================
  // Mode, bank and burst state
  sdc_state_e st_q, st_d;
  logic [ROW_W-1:0] mode_q, mode_d, ext_q, ext_d;
  logic loaded_q, loaded_d;
  logic [NBANK-1:0] open_q, open_d;
  logic [ROW_W-1:0] row_q [NBANK];
  logic [ROW_W-1:0] row_d [NBANK];
  logic [BA_W-1:0] bb_q, bb_d;
  logic [COL_W-1:0] start_q, start_d, mask_q, mask_d, cnt_q, cnt_d;
  logic full_q, full_d, il_q, il_d, ap_q, ap_d;
  logic [COL_W-1:0] nmask, iss_start, iss_mask, iss_k, iss_col;
  logic nfull, iss_v, iss_rd, iss_il, last;
  logic [BA_W-1:0] iss_bank;
  logic [2:0] bl;
  always_comb begin
    bl = mode_q[BL_LSB+:3];
    nmask = '0;
    nfull = 1'b0;
    if (bl <= BL_MAXC) begin
      nmask = COL_W'((1 << bl) - 1);
    end else if (bl == BL_FULL && !mode_q[BT_BIT]) begin
      nmask = '1;
      nfull = 1'b1;
    end
    // Reserved length codes and interleaved full page fall back to single beats
    if (code == CMD_WR && mode_q[WB_BIT]) begin
      nmask = '0;
      nfull = 1'b0;
    end
  end
  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    ext_d = ext_q;
    loaded_d = loaded_q;
    open_d = open_q;
    row_d = row_q;
    bb_d = bb_q;
    start_d = start_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    full_d = full_q;
    il_d = il_q;
    ap_d = ap_q;
    iss_v = 1'b0;
    iss_rd = st_q == ST_RD;
    iss_bank = bb_q;
    iss_start = start_q;
    iss_mask = mask_q;
    iss_il = il_q;
    iss_k = cnt_q + 1'b1;
    last = 1'b0;
    if (cke) begin
      if (st_q != ST_IDLE) begin
        iss_v = 1'b1;
        cnt_d = iss_k;
        last = !full_q && iss_k == mask_q;
      end
      if (cmd_ok) begin
        case (code)
          CMD_LMR: begin
            if (ba == SEL_EXT) begin
              ext_d = addr_bus;
            end else if (ba == SEL_BASE) begin
              mode_d = addr_bus;
              loaded_d = 1'b1;
            end
          end
          CMD_ACT: begin
            open_d[ba] = 1'b1;
            row_d[ba] = addr_bus;
          end
          CMD_RD, CMD_WR: begin
            iss_v = 1'b1;
            iss_rd = code == CMD_RD;
            iss_bank = ba;
            iss_start = addr_bus[COL_W-1:0];
            iss_mask = nmask;
            iss_il = mode_q[BT_BIT] && nmask != '0;
            iss_k = '0;
            st_d = iss_rd ? ST_RD : ST_WR;
            bb_d = ba;
            start_d = iss_start;
            mask_d = nmask;
            full_d = nfull;
            il_d = iss_il;
            ap_d = addr_bus[AP_BIT];
            cnt_d = '0;
            last = !nfull && nmask == '0;
          end
          CMD_PRE: begin
            if (addr_bus[AP_BIT]) begin
              open_d = '0;
            end else begin
              open_d[ba] = 1'b0;
            end
          end
          CMD_BST: begin
            st_d = ST_IDLE;
            last = 1'b0;
          end
          default: begin
          end
        endcase
      end
      if (last) begin
        st_d = ST_IDLE;
        if (ap_d) begin
          open_d[bb_d] = 1'b0;
        end
      end
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[3:2] == REG_CTRL && wb_sel_i[0]) begin
      blk_d = wb_dat_i[0];
    end else begin
      blk_d = blk_q;
    end
  end
  // Block-aligned column: upper bits fixed, offset wraps under the mask
  assign iss_col = (iss_start & ~iss_mask) |
    ((iss_il ? (iss_start ^ iss_k) : (iss_start + iss_k)) & iss_mask);
  // ==================================================================
  // Array, one byte lane per generate entry
  logic [BA_W+ROW_W+COL_W-1:0] full_idx;
  logic [MEM_AW-1:0] idx;
  logic [DQ_W-1:0] rdat;
  logic [1:0] bmask;
  assign full_idx = {iss_bank, row_q[iss_bank], iss_col};
  assign idx = full_idx[MEM_AW-1:0];
  assign bmask = {upper_byte_mask, lower_byte_mask};
  for (genvar gb = 0; gb < 2; gb++) begin : g_byte
    logic [7:0] mem [0:(1<<MEM_AW)-1];
    always_ff @(posedge sys_clk) begin
      if (iss_v && !iss_rd && !bmask[gb]) begin
        mem[idx] <= data_io_bus_in[gb*8+:8];
      end
    end
    assign rdat[gb*8+:8] = mem[idx];
  end
  // ==================================================================
  // Read latency pipe and byte-mask output enable
  logic [1:0] pv_q, pv_d, cl;
  logic [DQ_W-1:0] pd_q [2];
  logic [DQ_W-1:0] pd_d [2];
  logic [1:0] dm_q, dm_d;
  logic sel_v;
  logic [DQ_W-1:0] sel_dat, out_d, oe_d;
  assign cl = (mode_q[CL_LSB+:3] == 3'h1 || mode_q[CL_LSB+:3] == 3'h2) ? mode_q[CL_LSB+:2] : 2'h3;
  always_comb begin
    pv_d = pv_q;
    pd_d = pd_q;
    dm_d = dm_q;
    out_d = data_io_bus_out;
    oe_d = data_io_bus_oe;
    case (cl)
      2'h1: begin
        sel_v = iss_v && iss_rd;
        sel_dat = rdat;
      end
      2'h2: begin
        sel_v = pv_q[0];
        sel_dat = pd_q[0];
      end
      default: begin
        sel_v = pv_q[1];
        sel_dat = pd_q[1];
      end
    endcase
    if (cke) begin
      pv_d = {pv_q[0], iss_v && iss_rd};
      pd_d[0] = rdat;
      pd_d[1] = pd_q[0];
      dm_d = bmask;
      // Mask sampled one edge earlier gives the two-clock read latency
      out_d = sel_dat;
      oe_d = {{8{sel_v && !dm_q[1]}}, {8{sel_v && !dm_q[0]}}};
    end
  end
  // ==================================================================
  // Wishbone slave, one acknowledge per request, registered one cycle after the strobe
  logic [31:0] rd_d;
  logic ack_d;
  assign ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_comb begin
    case (wb_adr_i[3:2])
      REG_CTRL: rd_d = {31'h0, blk_q};
      REG_MODE: rd_d = {20'h0, mode_q};
      REG_EXT: rd_d = {20'h0, ext_q};
      REG_STAT: rd_d = {24'h0, loaded_q, !cke && st_q == ST_IDLE, st_q == ST_WR, st_q == ST_RD, open_q};
      default: rd_d = 32'h0;
    endcase
  end
  // ==================================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      mode_q <= MODE_RST;
      ext_q <= EXT_RST;
      loaded_q <= 1'b0;
      open_q <= '0;
      row_q <= '{default: '0};
      bb_q <= '0;
      start_q <= '0;
      mask_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      il_q <= 1'b0;
      ap_q <= 1'b0;
      blk_q <= 1'b0;
      pv_q <= '0;
      pd_q <= '{default: '0};
      dm_q <= '0;
      data_io_bus_out <= '0;
      data_io_bus_oe <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      ext_q <= ext_d;
      loaded_q <= loaded_d;
      open_q <= open_d;
      row_q <= row_d;
      bb_q <= bb_d;
      start_q <= start_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      il_q <= il_d;
      ap_q <= ap_d;
      blk_q <= blk_d;
      pv_q <= pv_d;
      pd_q <= pd_d;
      dm_q <= dm_d;
      data_io_bus_out <= out_d;
      data_io_bus_oe <= oe_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= rd_d;
    end
  end
  // ==================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_CS_MASK: assert property (cmd.cs_n |=> $stable(mode_q) && $stable(ext_q))
    else $error("deselected edge changed a mode register");
  AST_EXT_LOAD: assert property (cmd_ok && code == CMD_LMR && ba == SEL_EXT |=>
    ext_q == $past(addr_bus) && $stable(mode_q)) else $error("extended load wrong");
  AST_ACT_OPEN: assert property (cmd_ok && code == CMD_ACT |=> open_q[$past(ba)])
    else $error("activate did not open bank");
  AST_PRE_ALL: assert property (cmd_ok && code == CMD_PRE && addr_bus[AP_BIT] |=> open_q == '0)
    else $error("precharge all left a bank open");
  AST_RD_LAT2: assert property ((cmd_ok && code == CMD_RD && cl == 2'h2 && bmask == 2'h0) ##1 cke
    |=> data_io_bus_oe == 16'hFFFF) else $error("latency two read not driven");
  AST_RD_MASK: assert property ((cke && lower_byte_mask) ##1 cke |=> data_io_bus_oe[7:0] == 8'h00)
    else $error("masked read byte driven");
  AST_BL4_END: assert property ((cmd_ok && code == CMD_RD && bl == 3'h2) ##1 cke [*3] |=> st_q == ST_IDLE)
    else $error("four-beat burst did not end");
  AST_BLOCK: assert property (iss_v |-> (iss_col & ~iss_mask) == (iss_start & ~iss_mask))
    else $error("burst left its block");
  AST_SINGLE_WR: assert property (cmd_ok && code == CMD_WR && mode_q[WB_BIT] |=> st_q == ST_IDLE)
    else $error("single write kept bursting");
  AST_SUSPEND: assert property (!cke |=> $stable(cnt_q) && $stable(st_q) && $stable(open_q))
    else $error("gated clock advanced state");
  COV_READ: cover property (cmd_ok && code == CMD_RD ##3 data_io_bus_oe != '0);
  COV_WRITE: cover property (cmd_ok && code == CMD_WR && mask_d != '0);
  COV_FULL_BST: cover property (full_q && st_q == ST_RD && cmd_ok && code == CMD_BST);
  COV_EXT: cover property (cmd_ok && code == CMD_LMR && ba == SEL_EXT);
endmodule : sdc_core
`default_nettype wire

// *** verif/sdc_ctrl_model.sv ***
// Memory-controller stand-in: drives commands, address, masks, clock gate and write data.
// Assumes the bench calls its tasks just after a rising edge of sys_clk.
`default_nettype none
module sdc_ctrl_model
  import sdc_pkg::*;
#(
  parameter int WAIT_CYC = 20000
) (
  input wire logic sys_clk,
  output var sdc_pkg::sdc_cmd_s cmd,
  output var logic bank_sel_lo,
  output var logic bank_sel_hi,
  output var logic [sdc_pkg::ROW_W-1:0] addr_bus,
  output var logic lower_byte_mask,
  output var logic upper_byte_mask,
  output var logic clock_gate_input,
  output logic [sdc_pkg::DQ_W-1:0] data_io_bus_in,
  input wire logic [sdc_pkg::DQ_W-1:0] data_io_bus_out,
  input wire logic [sdc_pkg::DQ_W-1:0] data_io_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [sdc_pkg::DQ_W-1:0] drv_q = 16'h0000;
  // Idle value is inverted so stale data never looks valid
  assign data_io_bus_in = (data_io_bus_oe & data_io_bus_out) | (~data_io_bus_oe & drv_q);
  initial begin
    cmd = sdc_cmd_s'(4'h7);
    {bank_sel_hi, bank_sel_lo, upper_byte_mask, lower_byte_mask} = 4'h0;
    addr_bus = 12'h000;
    clock_gate_input = 1'b1;
  end
  task automatic issue(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a,
                       input logic [15:0] d, input logic [1:0] m);
    cmd <= sdc_cmd_s'(c);
    {bank_sel_hi, bank_sel_lo} <= ba;
    addr_bus <= a;
    drv_q <= d;
    {upper_byte_mask, lower_byte_mask} <= m;
    @(posedge sys_clk);
  endtask : issue
  // Back to no-operation; kept apart from issue so one step never drives a pin twice
  task automatic idle();
    cmd <= sdc_cmd_s'(4'h7);
    drv_q <= ~drv_q;
    {upper_byte_mask, lower_byte_mask} <= 2'h0;
  endtask : idle
  task automatic gate(input logic g);
    idle();
    clock_gate_input <= g;
    @(posedge sys_clk);
  endtask : gate
  task automatic power_up();
    repeat (WAIT_CYC) @(posedge sys_clk);
    issue(CMD_PRE, 2'h0, 12'h400, 16'h0000, 2'h0);
    issue(CMD_REF, 2'h0, 12'h000, 16'h0000, 2'h0);
    issue(CMD_REF, 2'h0, 12'h000, 16'h0000, 2'h0);
  endtask : power_up
endmodule : sdc_ctrl_model
`default_nettype wire

// *** verif/sdram_command_mode_burst_core_bench.sv ***
// Self-checking bench: bursts, mode loads, masks and Wishbone status of the core.
// Assumes the controller model sits on the memory side; bench acts as bus master.
`default_nettype none
module sdram_command_mode_burst_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdc_pkg::*;
  // ==================================================================
  // Signals
  logic sys_clk;
  logic sys_rst = 1'b1;
  sdc_cmd_s cmd;
  logic bank_sel_lo, bank_sel_hi, lower_byte_mask, upper_byte_mask, clock_gate_input;
  logic [ROW_W-1:0] addr_bus;
  logic [DQ_W-1:0] din, dout, doe;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic [WB_AW-1:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  int err_total = 0, checks_done = 0;
  logic [11:0] rmode [7] = '{12'h021, 12'h022, 12'h02A, 12'h03B, 12'h013, 12'h028, 12'h037};
  logic [8:0] rcol [7] = '{9'h001, 9'h001, 9'h001, 9'h005, 9'h006, 9'h003, 9'h1FF};
  sdc_core #(.MEM_AW(10)) i_sdc_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clock_gate_input(clock_gate_input), .cmd(cmd), .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi),
    .addr_bus(addr_bus), .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
    .data_io_bus_in(din), .data_io_bus_out(dout), .data_io_bus_oe(doe), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  sdc_ctrl_model i_sdc_ctrl_model (.sys_clk(sys_clk), .cmd(cmd), .bank_sel_lo(bank_sel_lo),
    .bank_sel_hi(bank_sel_hi), .addr_bus(addr_bus), .lower_byte_mask(lower_byte_mask),
    .upper_byte_mask(upper_byte_mask), .clock_gate_input(clock_gate_input), .data_io_bus_in(din),
    .data_io_bus_out(dout), .data_io_bus_oe(doe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==================================================================
  // Tasks
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: register %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    i_sdc_ctrl_model.idle();
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
    if (n >= 50) begin
      err_total++;
      $display("Error %0t: bus answer missing", $time);
      conclude();
    end
  endtask : wb
  function automatic logic [8:0] ecol(input logic [8:0] s, input int bl, input logic il, input int k);
    logic [8:0] msk;
    msk = 9'(bl - 1);
    if (il) return (s & ~msk) | ((s ^ 9'(k)) & msk);
    return (s & ~msk) | ((s + 9'(k)) & msk);
  endfunction : ecol
  task automatic load_mode(input logic [11:0] op);
    i_sdc_ctrl_model.issue(CMD_PRE, 2'h0, 12'h400, 16'h0000, 2'h0);
    i_sdc_ctrl_model.issue(CMD_LMR, SEL_BASE, op, 16'h0000, 2'h0);
    i_sdc_ctrl_model.issue(CMD_ACT, 2'h0, 12'h000, 16'h0000, 2'h0);
  endtask : load_mode
  task automatic burst(input logic [8:0] s, input int bl, input int m, input logic il, input int n);
    i_sdc_ctrl_model.issue(CMD_RD, 2'h0, {3'h0, s}, 16'h0000, 2'h0);
    i_sdc_ctrl_model.idle();
    repeat (m - 1) @(posedge sys_clk);
    for (int k = 0; k < n; k++) begin
      #1 chk16(dout, 16'hA000 + 16'(ecol(s, bl, il, k)));
      chk16(doe, 16'hFFFF);
      @(posedge sys_clk);
    end
    if (n == bl) begin
      #1 chk16(doe, 16'h0000);
      @(posedge sys_clk);
    end
  endtask : burst
  // ==================================================================
  // Sequence
  initial begin
    logic [31:0] q;
    int bl;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1 chk16(doe, 16'h0000);
    @(posedge sys_clk);
    wb(1'b0, 4'h4, 32'h0, q);
    chk32(q, {20'h0, MODE_RST});
    i_sdc_ctrl_model.power_up();
    load_mode(12'h020);
    for (int c = 0; c < 41; c++)
      i_sdc_ctrl_model.issue(CMD_WR, 2'h0, (c == 40) ? 12'h1FF : 12'(c), 16'hA000 + 16'((c == 40) ? 511 : c), 2'h0);
    i_sdc_ctrl_model.issue(4'hC, 2'h0, 12'h000, 16'h0BAD, 2'h0);
    i_sdc_ctrl_model.gate(1'b0);
    i_sdc_ctrl_model.issue(CMD_WR, 2'h0, 12'h000, 16'h0BAD, 2'h0);
    i_sdc_ctrl_model.gate(1'b1);
    wb(1'b1, 4'h0, 32'h1, q);
    i_sdc_ctrl_model.issue(CMD_WR, 2'h0, 12'h000, 16'h0BAD, 2'h0);
    wb(1'b1, 4'h0, 32'h0, q);
    burst(9'h000, 1, 2, 1'b0, 1);
    i_sdc_ctrl_model.issue(CMD_WR, 2'h0, 12'h01E, 16'h5A5A, 2'h1);
    i_sdc_ctrl_model.issue(CMD_RD, 2'h0, 12'h01E, 16'h0000, 2'h2);
    i_sdc_ctrl_model.idle();
    @(posedge sys_clk);
    #1 chk16(doe, 16'h00FF);
    chk16(dout & 16'h00FF, 16'h001E);
    repeat (3) @(posedge sys_clk);
    for (int r = 0; r < 7; r++) begin
      bl = (rmode[r][2:0] == BL_FULL) ? 512 : (1 << rmode[r][2:0]);
      load_mode(rmode[r]);
      wb(1'b0, 4'h4, 32'h0, q);
      chk32(q, {20'h0, rmode[r]});
      burst(rcol[r], bl, int'(rmode[r][6:4]), rmode[r][3], (bl > 8) ? 4 : bl);
      if (bl > 8) i_sdc_ctrl_model.issue(CMD_BST, 2'h0, 12'h000, 16'h0000, 2'h0);
      i_sdc_ctrl_model.idle();
      repeat (4) @(posedge sys_clk);
    end
    i_sdc_ctrl_model.issue(CMD_PRE, 2'h0, 12'h400, 16'h0000, 2'h0);
    i_sdc_ctrl_model.issue(CMD_LMR, SEL_EXT, 12'h005, 16'h0000, 2'h0);
    i_sdc_ctrl_model.issue(CMD_LMR, 2'h1, 12'h021, 16'h0000, 2'h0);
    wb(1'b0, 4'h8, 32'h0, q);
    chk32(q, 32'h5);
    wb(1'b0, 4'h4, 32'h0, q);
    chk32(q, 32'h37);
    load_mode(12'h222);
    i_sdc_ctrl_model.issue(CMD_WR, 2'h0, 12'h020, 16'hA020, 2'h0);
    i_sdc_ctrl_model.issue(4'h7, 2'h0, 12'h000, 16'h6666, 2'h0);
    burst(9'h020, 4, 2, 1'b0, 4);
    i_sdc_ctrl_model.issue(CMD_ACT, 2'h1, 12'h000, 16'h0000, 2'h0);
    i_sdc_ctrl_model.issue(CMD_PRE, 2'h1, 12'h000, 16'h0000, 2'h0);
    wb(1'b0, 4'hC, 32'h0, q);
    chk32({28'h0, q[3:0]}, 32'h1);
    i_sdc_ctrl_model.issue(CMD_RD, 2'h0, 12'h400, 16'h0000, 2'h0);
    i_sdc_ctrl_model.idle();
    repeat (8) @(posedge sys_clk);
    wb(1'b0, 4'hC, 32'h0, q);
    chk32({28'h0, q[3:0]}, 32'h0);
    conclude();
  end
endmodule : sdram_command_mode_burst_core_bench
`default_nettype wire
